// ===== rtl/input_sync.sv
// Purpose: three-flop synchronisers with agreement filter, divider halvers
// Assumes: sources are asynchronous to clock
// Notes:   divider inputs must be well below half the clock rate
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = loop_cfg_pkg::SRC_W
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] raw,
  status_src_if.producer        src
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [3:0]       half_reg;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end
    else
    begin
      stage1_reg <= raw;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      level_reg <= '0;
    else
      level_reg <= (stage2_reg ~^ stage3_reg) & stage2_reg
                 | (stage2_reg ^ stage3_reg) & level_reg;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_half
      // toggles on each filtered rising edge of a divider output
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          half_reg[g] <= 1'b0;
        else if (stage2_reg[loop_cfg_pkg::SRC_DIV_FIRST+g]
                 && stage3_reg[loop_cfg_pkg::SRC_DIV_FIRST+g]
                 && !level_reg[loop_cfg_pkg::SRC_DIV_FIRST+g])
          half_reg[g] <= ~half_reg[g];
      end
    end
  endgenerate

  assign src.level  = level_reg;
  assign src.halved = half_reg;
endmodule : input_sync

// ===== rtl/loop_cfg_pkg.sv
// Purpose: shared constants for the loop delay / status pin configuration bank
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   byte address of a register is four times its index
package loop_cfg_pkg;

  localparam int          ADDR_W             = 14;
  localparam int          SRC_W              = 12;
  localparam int          DIV_W              = 12;

  // register word indices; the byte address is the index times four
  localparam logic [11:0] IDX_PATH_DELAYS    = 12'h015E;
  localparam logic [11:0] IDX_STATUS_CFG     = 12'h015F;
  localparam logic [11:0] IDX_DIV_HIGH       = 12'h0160;
  localparam logic [11:0] IDX_DIV_LOW        = 12'h0161;
  localparam logic [11:0] IDX_LIVE_STATUS    = 12'h0180;

  // field positions
  localparam int          REF_DLY_LSB        = 3;
  localparam int          FB_DLY_LSB         = 0;
  localparam int          SEL_LSB            = 3;
  localparam int          TYPE_LSB           = 0;
  localparam int          DIV_HIGH_LSB       = 8;
  localparam int          INVALID_BIT        = 12;

  // reset values and writable-bit masks
  localparam logic [7:0]  PATH_DELAYS_RESET  = 8'h00;
  localparam logic [7:0]  STATUS_CFG_RESET   = 8'h0E;
  localparam logic [7:0]  DIV_HIGH_RESET     = 8'h00;
  localparam logic [7:0]  DIV_LOW_RESET      = 8'h02;
  localparam logic [7:0]  PATH_DELAYS_MASK   = 8'h3F;
  localparam logic [7:0]  DIV_HIGH_MASK      = 8'h0F;

  // delay step per code, in picoseconds
  localparam int          DELAY_STEP_PS      = 205;

  // source vector positions
  localparam int          SRC_LOCK1          = 0;
  localparam int          SRC_LOCK2          = 1;
  localparam int          SRC_HOLDOVER       = 2;
  localparam int          SRC_DAC_LOCKED     = 3;
  localparam int          SRC_READBACK       = 4;
  localparam int          SRC_DAC_RAIL       = 5;
  localparam int          SRC_DAC_LOW        = 6;
  localparam int          SRC_DAC_HIGH       = 7;
  localparam int          SRC_DIV_FIRST      = 8;

  typedef enum logic [2:0] {
    REG_NONE   = 3'b000,
    REG_DELAYS = 3'b001,
    REG_STATUS = 3'b010,
    REG_DIV_HI = 3'b011,
    REG_DIV_LO = 3'b100,
    REG_LIVE   = 3'b101
  } reg_sel_type;

  typedef enum logic [4:0] {
    SEL_LOW      = 5'h00,
    SEL_LOCK1    = 5'h01,
    SEL_LOCK2    = 5'h02,
    SEL_LOCK_AND = 5'h03,
    SEL_HOLDOVER = 5'h04,
    SEL_DAC_LOCK = 5'h05,
    SEL_READBACK = 5'h07,
    SEL_DAC_RAIL = 5'h08,
    SEL_DAC_LOW  = 5'h09,
    SEL_DAC_HIGH = 5'h0A,
    SEL_FB1      = 5'h0B,
    SEL_FB1_HALF = 5'h0C,
    SEL_FB2      = 5'h0D,
    SEL_FB2_HALF = 5'h0E,
    SEL_RD1      = 5'h0F,
    SEL_RD1_HALF = 5'h10,
    SEL_RD2      = 5'h11,
    SEL_RD2_HALF = 5'h12
  } status_select_type;

  typedef enum logic [2:0] {
    DRIVE_PUSH_PULL = 3'h3,
    DRIVE_INVERTED  = 3'h4,
    DRIVE_OPEN      = 3'h6
  } drive_type_type;

endpackage : loop_cfg_pkg

// ===== rtl/loop_delay_status_pin_cfg.sv
// Purpose: configuration bank for loop path delays, status pin and divider
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   read data are taken from next-state values, so a read right
//          after a write to the same register sees the new value
`timescale 1ns/1ps
module loop_delay_status_pin_cfg (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        firstLoopLock,
  input  wire logic        secondLoopLock,
  input  wire logic        holdover,
  input  wire logic        dacLocked,
  input  wire logic        serialReadback,
  input  wire logic        dacRail,
  input  wire logic        dacLow,
  input  wire logic        dacHigh,
  input  wire logic        firstLoopFeedbackDivider,
  input  wire logic        secondLoopFeedbackDivider,
  input  wire logic        firstLoopRefDivider,
  input  wire logic        secondLoopRefDividerOut,
  output logic      [2:0]  refPathDelay,
  output logic      [2:0]  feedbackPathDelay,
  output logic      [11:0] secondLoopRefDivider,
  output logic             statusPin1Out,
  output logic             statusPin1OeN
);
  logic [7:0]                     delays_reg;
  logic [7:0]                     delays_next;
  logic [7:0]                     statusCfg_reg;
  logic [7:0]                     statusCfg_next;
  logic [7:0]                     divHigh_reg;
  logic [7:0]                     divHigh_next;
  logic [7:0]                     divLow_reg;
  logic [7:0]                     divLow_next;
  logic                           wrPending_reg;
  loop_cfg_pkg::reg_sel_type      wrSel_reg;
  logic                           addrPhase;
  loop_cfg_pkg::reg_sel_type      addrSel;
  logic [31:0]                    rdata_next;
  logic [loop_cfg_pkg::SRC_W-1:0] rawSources;
  logic [loop_cfg_pkg::DIV_W-1:0] divNext;

  status_src_if srcBus ();

  function automatic loop_cfg_pkg::reg_sel_type decodeAddr(input logic [31:0] a);
    logic [loop_cfg_pkg::ADDR_W-1:0] low;
    low = a[loop_cfg_pkg::ADDR_W-1:0];
    decodeAddr = loop_cfg_pkg::REG_NONE;
    if (a[31:loop_cfg_pkg::ADDR_W] == '0)
    begin
      if (low == {loop_cfg_pkg::IDX_PATH_DELAYS, 2'b00})
        decodeAddr = loop_cfg_pkg::REG_DELAYS;
      else if (low == {loop_cfg_pkg::IDX_STATUS_CFG, 2'b00})
        decodeAddr = loop_cfg_pkg::REG_STATUS;
      else if (low == {loop_cfg_pkg::IDX_DIV_HIGH, 2'b00})
        decodeAddr = loop_cfg_pkg::REG_DIV_HI;
      else if (low == {loop_cfg_pkg::IDX_DIV_LOW, 2'b00})
        decodeAddr = loop_cfg_pkg::REG_DIV_LO;
      else if (low == {loop_cfg_pkg::IDX_LIVE_STATUS, 2'b00})
        decodeAddr = loop_cfg_pkg::REG_LIVE;
    end
  endfunction : decodeAddr

  function automatic logic hitsReg(input logic                      pending,
                                   input loop_cfg_pkg::reg_sel_type target,
                                   input loop_cfg_pkg::reg_sel_type sel);
    hitsReg = pending && (target == sel);
  endfunction : hitsReg

  assign addrPhase = hsel && htrans[1] && hready;
  assign addrSel   = decodeAddr(haddr);

  // write data phase: hwdata stands in the cycle after the address phase
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPending_reg <= 1'b0;
      wrSel_reg     <= loop_cfg_pkg::REG_NONE;
    end
    else if (hready)
    begin
      wrPending_reg <= addrPhase && hwrite;
      wrSel_reg     <= addrSel;
    end
  end

  // reserved bits are forced to zero on write
  always_comb
  begin
    delays_next = delays_reg;
    if (hitsReg(wrPending_reg, wrSel_reg, loop_cfg_pkg::REG_DELAYS))
      delays_next = hwdata[7:0] & loop_cfg_pkg::PATH_DELAYS_MASK;
  end

  always_comb
  begin
    statusCfg_next = statusCfg_reg;
    if (hitsReg(wrPending_reg, wrSel_reg, loop_cfg_pkg::REG_STATUS))
      statusCfg_next = hwdata[7:0];
  end

  always_comb
  begin
    divHigh_next = divHigh_reg;
    if (hitsReg(wrPending_reg, wrSel_reg, loop_cfg_pkg::REG_DIV_HI))
      divHigh_next = hwdata[7:0] & loop_cfg_pkg::DIV_HIGH_MASK;
  end

  always_comb
  begin
    divLow_next = divLow_reg;
    if (hitsReg(wrPending_reg, wrSel_reg, loop_cfg_pkg::REG_DIV_LO))
      divLow_next = hwdata[7:0];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      delays_reg <= loop_cfg_pkg::PATH_DELAYS_RESET;
    else
      delays_reg <= delays_next;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      statusCfg_reg <= loop_cfg_pkg::STATUS_CFG_RESET;
    else
      statusCfg_reg <= statusCfg_next;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      divHigh_reg <= loop_cfg_pkg::DIV_HIGH_RESET;
    else
      divHigh_reg <= divHigh_next;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      divLow_reg <= loop_cfg_pkg::DIV_LOW_RESET;
    else
      divLow_reg <= divLow_next;
  end

  // delay codes go out as codes; each step is DELAY_STEP_PS of analog delay
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refPathDelay      <= '0;
      feedbackPathDelay <= '0;
    end
    else
    begin
      refPathDelay      <= delays_next[loop_cfg_pkg::REF_DLY_LSB +: 3];
      feedbackPathDelay <= delays_next[loop_cfg_pkg::FB_DLY_LSB +: 3];
    end
  end

  // divide by zero is not valid: the loop keeps the last valid ratio
  assign divNext = {divHigh_next[3:0], divLow_next};
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      secondLoopRefDivider <= {loop_cfg_pkg::DIV_HIGH_RESET[3:0], loop_cfg_pkg::DIV_LOW_RESET};
    else if (divNext != '0)
      secondLoopRefDivider <= divNext;
  end

  always_comb
  begin
    rdata_next = '0;
    unique case (addrSel)
      loop_cfg_pkg::REG_DELAYS: rdata_next[7:0] = delays_next;
      loop_cfg_pkg::REG_STATUS: rdata_next[7:0] = statusCfg_next;
      loop_cfg_pkg::REG_DIV_HI: rdata_next[7:0] = divHigh_next;
      loop_cfg_pkg::REG_DIV_LO: rdata_next[7:0] = divLow_next;
      loop_cfg_pkg::REG_LIVE:
      begin
        rdata_next[loop_cfg_pkg::SRC_W-1:0] = srcBus.level;
        rdata_next[loop_cfg_pkg::INVALID_BIT] = (divNext == '0);
      end
      default:                  rdata_next = '0;
    endcase
  end

  // unmapped reads return zero; hrdata holds until the next read
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= '0;
    else if (addrPhase && !hwrite)
      hrdata <= rdata_next;
  end

  // zero wait states, always OKAY; kept in flops so bus outputs stay registered
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hreadyout <= 1'b1;
    else
      hreadyout <= 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  assign rawSources = {secondLoopRefDividerOut, firstLoopRefDivider,
                       secondLoopFeedbackDivider, firstLoopFeedbackDivider,
                       dacHigh, dacLow, dacRail, serialReadback,
                       dacLocked, holdover, secondLoopLock, firstLoopLock};

  input_sync #(
    .WIDTH (loop_cfg_pkg::SRC_W)
  ) syncInst (
    .clock (clock),
    .rst_n (rst_n),
    .raw   (rawSources),
    .src   (srcBus.producer)
  );

  // codes 17/18 assume software keeps the second pin off its lock codes
  pin_driver pinInst (
    .clock     (clock),
    .rst_n     (rst_n),
    .select    (statusCfg_reg[loop_cfg_pkg::SEL_LSB +: 5]),
    .driveType (statusCfg_reg[loop_cfg_pkg::TYPE_LSB +: 3]),
    .src       (srcBus.consumer),
    .pinOut    (statusPin1Out),
    .pinOeN    (statusPin1OeN)
  );
endmodule : loop_delay_status_pin_cfg

// ===== rtl/pin_driver.sv
// Purpose: selects and drives the first status pin
// Assumes: select and drive type come from the configuration registers
// Notes:   reserved select codes choose a low source, reserved drive types release the pin
`timescale 1ns/1ps
module pin_driver (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [4:0] select,
  input  wire logic [2:0] driveType,
  status_src_if.consumer  src,
  output logic            pinOut,
  output logic            pinOeN
);
  logic chosen;

  always_comb
  begin
    chosen = 1'b0;
    unique case (select)
      loop_cfg_pkg::SEL_LOW:      chosen = 1'b0;
      loop_cfg_pkg::SEL_LOCK1:    chosen = src.level[loop_cfg_pkg::SRC_LOCK1];
      loop_cfg_pkg::SEL_LOCK2:    chosen = src.level[loop_cfg_pkg::SRC_LOCK2];
      loop_cfg_pkg::SEL_LOCK_AND: chosen = src.level[loop_cfg_pkg::SRC_LOCK1]
                                         & src.level[loop_cfg_pkg::SRC_LOCK2];
      loop_cfg_pkg::SEL_HOLDOVER: chosen = src.level[loop_cfg_pkg::SRC_HOLDOVER];
      loop_cfg_pkg::SEL_DAC_LOCK: chosen = src.level[loop_cfg_pkg::SRC_DAC_LOCKED];
      loop_cfg_pkg::SEL_READBACK: chosen = src.level[loop_cfg_pkg::SRC_READBACK];
      loop_cfg_pkg::SEL_DAC_RAIL: chosen = src.level[loop_cfg_pkg::SRC_DAC_RAIL];
      loop_cfg_pkg::SEL_DAC_LOW:  chosen = src.level[loop_cfg_pkg::SRC_DAC_LOW];
      loop_cfg_pkg::SEL_DAC_HIGH: chosen = src.level[loop_cfg_pkg::SRC_DAC_HIGH];
      loop_cfg_pkg::SEL_FB1:      chosen = src.level[loop_cfg_pkg::SRC_DIV_FIRST];
      loop_cfg_pkg::SEL_FB1_HALF: chosen = src.halved[0];
      loop_cfg_pkg::SEL_FB2:      chosen = src.level[loop_cfg_pkg::SRC_DIV_FIRST+1];
      loop_cfg_pkg::SEL_FB2_HALF: chosen = src.halved[1];
      loop_cfg_pkg::SEL_RD1:      chosen = src.level[loop_cfg_pkg::SRC_DIV_FIRST+2];
      loop_cfg_pkg::SEL_RD1_HALF: chosen = src.halved[2];
      loop_cfg_pkg::SEL_RD2:      chosen = src.level[loop_cfg_pkg::SRC_DIV_FIRST+3];
      loop_cfg_pkg::SEL_RD2_HALF: chosen = src.halved[3];
      default:                    chosen = 1'b0; // code 6 and 19..31
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinOut <= 1'b0;
      pinOeN <= 1'b1;
    end
    else
    begin
      unique case (driveType)
        loop_cfg_pkg::DRIVE_PUSH_PULL:
        begin
          pinOut <= chosen;
          pinOeN <= 1'b0;
        end
        loop_cfg_pkg::DRIVE_INVERTED:
        begin
          pinOut <= ~chosen;
          pinOeN <= 1'b0;
        end
        loop_cfg_pkg::DRIVE_OPEN:
        begin
          // open drain only ever pulls low; high is released
          pinOut <= 1'b0;
          pinOeN <= chosen;
        end
        default:
        begin
          pinOut <= 1'b0;
          pinOeN <= 1'b1;
        end
      endcase
    end
  end
endmodule : pin_driver

// ===== rtl/status_src_if.sv
// Purpose: carries filtered status sources between sync and pin driver
// Assumes: one clock domain
// Notes:   halved holds the four divider outputs divided by two
`timescale 1ns/1ps
interface status_src_if;
  logic [loop_cfg_pkg::SRC_W-1:0] level;
  logic [3:0]                     halved;
  modport producer (output level, output halved);
  modport consumer (input level, input halved);
endinterface : status_src_if

// ===== verification/loop_cfg_assertions.sv
// Purpose: concurrent checks on the configuration bank ports
// Assumes: hreadyout is the bus ready, zero wait states
// Notes:   helper flops mark the data phase of each taken request
`timescale 1ns/1ps
module loop_cfg_assertions (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [2:0]  refPathDelay,
  input wire logic [2:0]  feedbackPathDelay,
  input wire logic [11:0] secondLoopRefDivider
);
  logic        phValid;
  logic        phWrite;
  logic [31:0] phAddr;
  logic        wrDelays;
  logic        wrDivAny;
  assign wrDelays = phValid && phWrite && phAddr == 32'h0000_0578;
  assign wrDivAny = phValid && phWrite && (phAddr == 32'h0000_0580 || phAddr == 32'h0000_0584);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phValid <= 1'b0;
      phWrite <= 1'b0;
      phAddr  <= 32'h0000_0000;
    end
    else
    begin
      phValid <= hsel && htrans[1] && hready;
      phWrite <= hwrite;
      phAddr  <= haddr;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // data phase of a request, then the edge that commits it
  sequence s_phase(w, a);
    phValid && phWrite == w && phAddr == a;
  endsequence
  sequence s_low_write;
    s_phase(1'b1, 32'h0000_0584) ##0 hwdata[7:0] != 8'h00;
  endsequence

  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_delay_write: assert property (s_phase(1'b1, 32'h0000_0578) |=>
    {refPathDelay, feedbackPathDelay} == $past(hwdata[5:0])) else $error("delay not written");
  a_delay_cause: assert property (!$stable({refPathDelay, feedbackPathDelay}) |->
    $past(wrDelays)) else $error("delay changed without write");
  a_div_low: assert property (s_low_write |=>
    secondLoopRefDivider[7:0] == $past(hwdata[7:0])) else $error("divider low not written");
  a_div_cause: assert property (!$stable(secondLoopRefDivider) |-> $past(wrDivAny))
    else $error("divider changed without write");
  a_div_nonzero: assert property (secondLoopRefDivider != 12'h000)
    else $error("divider zero");
  a_reset_vals: assert property ($rose(rst_n) |-> refPathDelay == 3'h0 &&
    feedbackPathDelay == 3'h0 && secondLoopRefDivider == 12'h002) else $error("bad reset");
  a_read_delays: assert property (s_phase(1'b0, 32'h0000_0578) |->
    hrdata == {26'h000_0000, refPathDelay, feedbackPathDelay}) else $error("delay readback");
  a_hi_reserved: assert property (s_phase(1'b0, 32'h0000_0580) |->
    hrdata[31:4] == 28'h000_0000) else $error("divider high reserved bits set");
endmodule : loop_cfg_assertions

bind loop_delay_status_pin_cfg loop_cfg_assertions u_chk (
  .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .refPathDelay(refPathDelay),
  .feedbackPathDelay(feedbackPathDelay), .secondLoopRefDivider(secondLoopRefDivider)
);

// ===== verification/test_loop_delay_status_pin_cfg.sv
// Purpose: self-checking bench for the configuration bank over AHB-Lite
// Assumes: status sources reach the pin within eight cycles
// Notes:   bus calls wait on hready; only the watchdog ends a hung wait
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    n_checks++; \
    if ((a) !== (e)) \
    begin \
      mismatches++; \
      $display("ERROR %0t: got %0h expected %0h", $time, (a), (e)); \
    end \
  end
module test_loop_delay_status_pin_cfg;
  localparam logic [31:0] A_DLY = {18'h0_0000, loop_cfg_pkg::IDX_PATH_DELAYS, 2'b00};
  localparam logic [31:0] A_STS = {18'h0_0000, loop_cfg_pkg::IDX_STATUS_CFG, 2'b00};
  localparam logic [31:0] A_DHI = {18'h0_0000, loop_cfg_pkg::IDX_DIV_HIGH, 2'b00};
  localparam logic [31:0] A_DLO = {18'h0_0000, loop_cfg_pkg::IDX_DIV_LOW, 2'b00};
  // one-hot source index per level select code
  localparam int SRC_OF[11] = '{0, 0, 1, 0, 2, 3, 0, 4, 5, 6, 7};
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic [7:0]  lv = 8'h00;
  logic [3:0]  dv = 4'h0;
  logic [2:0]  refDly;
  logic [2:0]  fbDly;
  logic [11:0] divOut;
  logic        pinOut;
  logic        pinOeN;
  logic        p;
  int          mismatches = 0;
  int          n_checks = 0;

  always #20 clock = ~clock;

  loop_delay_status_pin_cfg u_dut (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .firstLoopLock(lv[0]), .secondLoopLock(lv[1]),
    .holdover(lv[2]), .dacLocked(lv[3]), .serialReadback(lv[4]), .dacRail(lv[5]),
    .dacLow(lv[6]), .dacHigh(lv[7]), .firstLoopFeedbackDivider(dv[0]),
    .secondLoopFeedbackDivider(dv[1]), .firstLoopRefDivider(dv[2]),
    .secondLoopRefDividerOut(dv[3]), .refPathDelay(refDly), .feedbackPathDelay(fbDly),
    .secondLoopRefDivider(divOut), .statusPin1Out(pinOut), .statusPin1OeN(pinOeN)
  );

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clock); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic wrReg(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    ahb(1'b1, a, {24'h00_0000, d}, r);
  endtask : wrReg

  task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0000_0000, r);
    `CHK(r, e)
  endtask : rdChk

  task automatic settle;
    repeat (8) @(posedge clock);
  endtask : settle

  task automatic endTest(input string name);
    $display("test %s done, checks %0d", name, n_checks);
  endtask : endTest

  // open drain default: lock low pulls the pin down
  task automatic checkDefaults;
    rdChk(A_DLY, 32'h0000_0000);
    rdChk(A_STS, {24'h00_0000, 5'd1, 3'd6});
    rdChk(A_DHI, 32'h0000_0000);
    rdChk(A_DLO, 32'h0000_0002);
    `CHK({refDly, fbDly, divOut}, {6'h00, 12'h002})
    settle;
    `CHK({pinOut, pinOeN}, 2'b00)
  endtask : checkDefaults

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  initial
  begin
    #(40 * 20000);
    mismatches++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    checkDefaults();
    endTest("defaults");
    for (int i = 0; i < 8; i++)
    begin
      wrReg(A_DLY, {2'b00, 3'(i), 3'(7 - i)});
      rdChk(A_DLY, {26'h000_0000, 3'(i), 3'(7 - i)});
      `CHK({refDly, fbDly}, {3'(i), 3'(7 - i)})
    end
    rdChk(32'h0000_0700, 32'h0000_0000);
    wrReg(32'h0000_0700, 8'hFF);
    rdChk(A_DLY, 32'h0000_0038);
    endTest("delays");
    for (int c = 0; c <= 10; c++)
    begin
      for (int k = 0; k < 2 && c != 6; k++)
      begin
        lv <= k ? 8'hFF : 8'(1 << SRC_OF[c]);
        wrReg(A_STS, {5'(c), 3'd3});
        settle;
        p = (c == 0) ? 1'b0 : (c == 3) ? (k == 1) : (c == 1 || k == 1 || SRC_OF[c] != 0);
        `CHK({pinOut, pinOeN}, {p, 1'b0})
      end
    end
    endTest("levels");
    // rows: type, lock, pin, enable
    for (int j = 0; j < 5; j++)
    begin
      lv <= {7'h00, j != 2 && j != 4};
      wrReg(A_STS, {5'd1, (j == 0) ? 3'd3 : (j < 3) ? 3'd4 : 3'd6});
      settle;
      `CHK({pinOut, pinOeN}, {j == 0 || j == 2, j == 3})
    end
    endTest("drive");
    for (int c = 11; c <= 18; c++)
    begin
      wrReg(A_STS, {5'(c), 3'd3});
      settle;
      p = pinOut;
      `CHK(p === 1'b0 || p === 1'b1, 1'b1)
      for (int n = 0; n < 2; n++)
      begin
        dv[(c - 11) / 2] <= 1'b1;
        settle;
        if (c % 2)
          `CHK(pinOut, 1'b1)
        dv[(c - 11) / 2] <= 1'b0;
        settle;
        `CHK(pinOut, (c % 2) ? 1'b0 : p ^ (n == 0))
      end
    end
    endTest("dividers");
    wrReg(A_DHI, 8'h0A);
    wrReg(A_DLO, 8'hBC);
    rdChk(A_DLO, 32'h0000_00BC);
    `CHK(divOut, 12'hABC)
    wrReg(A_DHI, 8'h00);
    wrReg(A_DLO, 8'h00);
    rdChk(A_DLO, 32'h0000_0000);
    rdChk({18'h0_0000, loop_cfg_pkg::IDX_LIVE_STATUS, 2'b00}, 32'h0000_1000);
    `CHK(divOut, 12'h0BC)
    wrReg(A_DHI, 8'h0F);
    wrReg(A_DLO, 8'hFF);
    rdChk(A_DHI, 32'h0000_000F);
    `CHK(divOut, 12'hFFF)
    endTest("divider");
    lv <= 8'h00;
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    checkDefaults();
    endTest("reset again");
    conclude();
  end
endmodule : test_loop_delay_status_pin_cfg
